// >>> logic/iox_expander.sv
// Top of the four-bit I2C I/O expander: serial slave engine and port registers.
`timescale 1ns/1ps
`default_nettype none

module iox_expander (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_N,
  // Serial bus; SDA is open drain and only ever pulled low.
  input wire logic SCL,
  input wire logic SDA,
  output logic SDA_DATA,
  output logic SDA_OE,
  // Port pins.
  input wire logic [iox_pkg::NUM_PINS-1:0] GPIO_PIN,
  output logic [iox_pkg::NUM_PINS-1:0] GPIO_PIN_LATCH,
  output logic [iox_pkg::NUM_PINS-1:0] GPIO_PIN_OE
);

  logic [iox_pkg::COND_W-1:0] clean;
  logic scl_f;
  logic sda_f;
  logic [3:0] level_bits;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  iox_pkg::iox_state_t state_reg;
  iox_pkg::iox_state_t state_next;
  iox_pkg::iox_kind_t kind_reg;
  iox_pkg::iox_kind_t kind_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic full_reg;
  logic full_next;
  logic read_reg;
  logic read_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic [1:0] ptr_reg;
  logic [1:0] ptr_next;
  logic [3:0] latch_reg;
  logic [3:0] latch_next;
  logic [3:0] polarity_reg;
  logic [3:0] polarity_next;
  logic [3:0] drive_en_reg;
  logic [3:0] drive_en_next;

  //////////////////////////////////////////////////////////////////////////////

  // Byte that a read returns for the current pointer.
  function automatic logic [7:0] read_value(input logic [1:0] ptr, input logic [3:0] lvl, input logic [3:0] lat,
                                            input logic [3:0] pol, input logic [3:0] drv);
    logic [7:0] v;
    v = 8'h00;
    case (ptr)
      iox_pkg::PTR_LEVELS: v = {iox_pkg::LEVELS_HIGH_NIBBLE, lvl ^ pol};
      iox_pkg::PTR_LATCH: v = {iox_pkg::LATCH_HIGH_NIBBLE, lat};
      iox_pkg::PTR_POLARITY: v = {iox_pkg::POLARITY_HIGH_NIBBLE, pol};
      iox_pkg::PTR_DIRECTION: v = {iox_pkg::DIRECTION_HIGH_NIBBLE, ~drv};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_value

  //////////////////////////////////////////////////////////////////////////////

  // All six inputs share one conditioner so they see equal delay.
  iox_input_cond u_cond (
    .clk(MCLK),
    .rst_n(RST_N),
    .raw_in({GPIO_PIN, SDA, SCL}),
    .clean_out(clean)
  );

  assign scl_f = clean[0];
  assign sda_f = clean[1];
  assign level_bits = clean[5:2];

  // Edge and condition detection on the filtered bus lines.
  assign scl_rise = scl_f & ~scl_prev_reg;
  assign scl_fall = ~scl_f & scl_prev_reg;
  assign start_seen = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
  assign stop_seen = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;

  //////////////////////////////////////////////////////////////////////////////

  // Serial engine; SDA is changed only after SCL falls, which gives data hold for free.
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    full_next = full_reg;
    read_next = read_reg;
    sda_oe_next = sda_oe_reg;
    ptr_next = ptr_reg;
    latch_next = latch_reg;
    polarity_next = polarity_reg;
    drive_en_next = drive_en_reg;
    if (start_seen) begin
      // A repeated start restarts address reception from any state.
      state_next = iox_pkg::ST_RX;
      kind_next = iox_pkg::KIND_ADDR;
      bit_cnt_next = 3'h0;
      full_next = 1'b0;
      sda_oe_next = 1'b0;
    end else if (stop_seen) begin
      state_next = iox_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      case (state_reg)
        iox_pkg::ST_IDLE: begin
          sda_oe_next = 1'b0;
        end
        iox_pkg::ST_RX: begin
          if (scl_rise && !full_reg) begin
            shift_next = {shift_reg[6:0], sda_f};
            bit_cnt_next = bit_cnt_reg + 3'h1;
            full_next = (bit_cnt_reg == 3'h7);
          end else if (scl_fall && full_reg) begin
            full_next = 1'b0;
            case (kind_reg)
              iox_pkg::KIND_ADDR: begin
                if (shift_reg[7:1] == iox_pkg::SLAVE_ADDR) begin
                  read_next = shift_reg[iox_pkg::RW_BIT];
                  sda_oe_next = 1'b1;
                  state_next = iox_pkg::ST_ACK;
                end else begin
                  state_next = iox_pkg::ST_WAIT;
                end
              end
              iox_pkg::KIND_CMD: begin
                ptr_next = shift_reg[1:0];
                sda_oe_next = 1'b1;
                state_next = iox_pkg::ST_ACK;
              end
              default: begin
                // Data write; the input register takes the byte and keeps nothing.
                case (ptr_reg)
                  iox_pkg::PTR_LATCH: latch_next = shift_reg[3:0];
                  iox_pkg::PTR_POLARITY: polarity_next = shift_reg[3:0];
                  iox_pkg::PTR_DIRECTION: drive_en_next = ~shift_reg[3:0];
                  default: ;
                endcase
                sda_oe_next = 1'b1;
                state_next = iox_pkg::ST_ACK;
              end
            endcase
          end
        end
        iox_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 3'h0;
            if (read_reg) begin
              shift_next = read_value(ptr_reg, level_bits, latch_reg, polarity_reg, drive_en_reg);
              sda_oe_next = ~shift_next[7];
              state_next = iox_pkg::ST_TX;
            end else begin
              kind_next = (kind_reg == iox_pkg::KIND_ADDR) ? iox_pkg::KIND_CMD : iox_pkg::KIND_DATA;
              sda_oe_next = 1'b0;
              state_next = iox_pkg::ST_RX;
            end
          end
        end
        iox_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 3'h7) begin
              sda_oe_next = 1'b0;
              full_next = 1'b0;
              state_next = iox_pkg::ST_MACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              bit_cnt_next = bit_cnt_reg + 3'h1;
              sda_oe_next = ~shift_reg[6];
            end
          end
        end
        iox_pkg::ST_MACK: begin
          // The master's acknowledge bit is kept in the full flag until SCL falls.
          if (scl_rise) begin
            full_next = ~sda_f;
          end else if (scl_fall) begin
            full_next = 1'b0;
            bit_cnt_next = 3'h0;
            if (full_reg) begin
              shift_next = read_value(ptr_reg, level_bits, latch_reg, polarity_reg, drive_en_reg);
              sda_oe_next = ~shift_next[7];
              state_next = iox_pkg::ST_TX;
            end else begin
              state_next = iox_pkg::ST_WAIT;
            end
          end
        end
        iox_pkg::ST_WAIT: begin
          sda_oe_next = 1'b0;
        end
        default: begin
          state_next = iox_pkg::ST_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  // Registers of the engine and the port; reset gives inputs and a high latch.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      state_reg <= iox_pkg::ST_IDLE;
      kind_reg <= iox_pkg::KIND_ADDR;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      full_reg <= 1'b0;
      read_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ptr_reg <= iox_pkg::PTR_RESET;
      latch_reg <= iox_pkg::LATCH_RESET;
      polarity_reg <= iox_pkg::POLARITY_RESET;
      drive_en_reg <= iox_pkg::DRIVE_EN_RESET;
    end else begin
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
      state_reg <= state_next;
      kind_reg <= kind_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      full_reg <= full_next;
      read_reg <= read_next;
      sda_oe_reg <= sda_oe_next;
      ptr_reg <= ptr_next;
      latch_reg <= latch_next;
      polarity_reg <= polarity_next;
      drive_en_reg <= drive_en_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Outputs other than the tied-low SDA_DATA come straight from flops; the latch always reaches the pin, the enable decides.
  assign SDA_DATA = 1'b0;
  assign SDA_OE = sda_oe_reg;
  assign GPIO_PIN_LATCH = latch_reg;
  assign GPIO_PIN_OE = drive_en_reg;

endmodule : iox_expander

`default_nettype wire

// >>> logic/iox_pkg.sv
// Package of constants and types for the four-bit I2C I/O expander.
//
// Contract
// - Answer only slave address 1000001 in bits 7..1; bit 0 high means read.
// - First byte after a write address is the command byte, latched as pointer.
// - Pointer 0 input levels, 1 output latch, 2 polarity, 3 direction.
// - Input levels reflect every pin's sampled level, whatever its direction.
// - Input register is read-only; writes to it are acked and change nothing.
// - Input register bits 7..4 read one; bits 3..0 follow the pins.
// - Clock and data inputs ignore glitches of up to 50 ns.
// - Pointer never auto-increments; repeated reads hit the same register.
// - Set polarity bits invert the matching input bits on reads; reset zero.
// - Set direction bit makes pin an input, clear drives latch; reset ones.
// - Output latch reads back stored value, resets to ones, ignored on inputs.
package iox_pkg;

  // Slave address and transfer direction bit.
  localparam logic [6:0] SLAVE_ADDR = 7'h41;
  localparam int RW_BIT = 0;

  // Command byte values selecting the registers.
  localparam logic [1:0] PTR_LEVELS = 2'h0;
  localparam logic [1:0] PTR_LATCH = 2'h1;
  localparam logic [1:0] PTR_POLARITY = 2'h2;
  localparam logic [1:0] PTR_DIRECTION = 2'h3;
  localparam logic [1:0] PTR_RESET = 2'h0;

  // Pin count and register fill values.
  localparam int NUM_PINS = 4;
  localparam logic [3:0] LEVELS_HIGH_NIBBLE = 4'hf;
  localparam logic [3:0] LATCH_RESET = 4'hf;
  localparam logic [3:0] POLARITY_RESET = 4'h0;
  localparam logic [3:0] DRIVE_EN_RESET = 4'h0;
  localparam logic [3:0] LATCH_HIGH_NIBBLE = 4'hf;
  localparam logic [3:0] POLARITY_HIGH_NIBBLE = 4'h0;
  localparam logic [3:0] DIRECTION_HIGH_NIBBLE = 4'hf;

  // Input conditioner: SCL, SDA and the four pins, all idle high.
  localparam int COND_W = 6;
  localparam logic [5:0] COND_RESET = 6'h3f;

  // Spike suppression time and its count of MCLK cycles, rounded up.
  localparam int SPIKE_NS = 50;
  localparam int MCLK_KHZ = 25000;
  localparam int FILT_CYCLES = (SPIKE_NS * MCLK_KHZ + 999999) / 1000000;
  localparam int CNT_W = 2;

  // Serial engine states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_WAIT
  } iox_state_t;

  // Which byte of the transfer is being received.
  typedef enum logic [1:0] {
    KIND_ADDR,
    KIND_CMD,
    KIND_DATA
  } iox_kind_t;

endpackage : iox_pkg

// >>> logic/iox_input_cond.sv
// Three-flop synchroniser and spike filter for the serial and pin inputs.
`timescale 1ns/1ps
`default_nettype none

module iox_input_cond (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw asynchronous inputs.
  input wire logic [iox_pkg::COND_W-1:0] raw_in,
  // Filtered levels.
  output logic [iox_pkg::COND_W-1:0] clean_out
);

  logic [iox_pkg::COND_W-1:0] s1_reg;
  logic [iox_pkg::COND_W-1:0] s2_reg;
  logic [iox_pkg::COND_W-1:0] s3_reg;
  logic [iox_pkg::COND_W-1:0] out_reg;
  logic [iox_pkg::COND_W-1:0] out_next;
  logic [iox_pkg::CNT_W-1:0] cnt_reg [iox_pkg::COND_W];
  logic [iox_pkg::CNT_W-1:0] cnt_next [iox_pkg::COND_W];

  //////////////////////////////////////////////////////////////////////////////

  // A new level is taken only after stages two and three agree for longer than a spike can last.
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < iox_pkg::COND_W; i++) begin
      cnt_next[i] = '0;
      if (s2_reg[i] == s3_reg[i] && s3_reg[i] != out_reg[i]) begin
        if (cnt_reg[i] == iox_pkg::CNT_W'(iox_pkg::FILT_CYCLES)) begin
          out_next[i] = s3_reg[i];
        end else begin
          cnt_next[i] = cnt_reg[i] + iox_pkg::CNT_W'(1);
        end
      end
    end
  end

  // Stage one feeds stage two only, so no logic sees a metastable value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= iox_pkg::COND_RESET;
      s2_reg <= iox_pkg::COND_RESET;
      s3_reg <= iox_pkg::COND_RESET;
      out_reg <= iox_pkg::COND_RESET;
      for (int i = 0; i < iox_pkg::COND_W; i++) begin
        cnt_reg[i] <= '0;
      end
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
      for (int i = 0; i < iox_pkg::COND_W; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  assign clean_out = out_reg;

endmodule : iox_input_cond

`default_nettype wire

// >>> sim/iox_expander_sva.sv
// Port checker for the four-bit I/O expander.
`timescale 1ns/1ps
`default_nettype none

module iox_expander_chk (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_N,
  // Serial bus.
  input wire logic SCL,
  input wire logic SDA,
  input wire logic SDA_DATA,
  input wire logic SDA_OE,
  // Port pins.
  input wire logic [iox_pkg::NUM_PINS-1:0] GPIO_PIN,
  input wire logic [iox_pkg::NUM_PINS-1:0] GPIO_PIN_LATCH,
  input wire logic [iox_pkg::NUM_PINS-1:0] GPIO_PIN_OE
);
  //////////////////////////////
  // The device may only move SDA while SCL is low, or a master would see a false START or STOP.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence scl_low_s;
    !SCL;
  endsequence
  sequence pull_s;
    $rose(SDA_OE);
  endsequence
  sda_zero_a: assert property (SDA_DATA == 1'b0) else $error("SDA data not low");
  pull_low_a: assert property (pull_s |-> scl_low_s) else $error("SDA pulled in SCL high");
  free_low_a: assert property ($fell(SDA_OE) |-> scl_low_s) else $error("SDA freed in SCL high");
  hold_high_a: assert property (SCL && $past(SCL) |-> $stable(SDA_OE)) else $error("SDA moved");
  latch_move_a: assert property ($changed(GPIO_PIN_LATCH) |-> scl_low_s) else $error("Latch moved");
  dir_move_a: assert property ($changed(GPIO_PIN_OE) |-> scl_low_s) else $error("Drive moved");
  reset_val_a: assert property ($rose(RST_N) |-> GPIO_PIN_LATCH == 4'hf && GPIO_PIN_OE == 4'h0 && !SDA_OE)
    else $error("Bad reset state");
  pull_end_a: assert property (pull_s |-> ##[1:400] !SDA_OE) else $error("SDA held too long");
endmodule : iox_expander_chk

bind iox_expander iox_expander_chk chk_u (.MCLK(MCLK), .RST_N(RST_N), .SCL(SCL), .SDA(SDA),
  .SDA_DATA(SDA_DATA), .SDA_OE(SDA_OE), .GPIO_PIN(GPIO_PIN),
  .GPIO_PIN_LATCH(GPIO_PIN_LATCH), .GPIO_PIN_OE(GPIO_PIN_OE));

`default_nettype wire

// >>> sim/iox_bus_master.sv
// Bus master model driving SCL and SDA toward the expander.
`timescale 1ns/1ps
`default_nettype none

module iox_bus_master (
  // Wire levels.
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  //////////////////////////////
  // Whole MCLK cycles, so every edge stays just after a clock edge.
  localparam int HALF = 480;
  localparam int QTR = 240;
  // Idle bus: both lines released.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // START, or a repeated START when SCL is low.
  task automatic start();
    if (!scl) begin
      sda_low = 1'b0;
      #QTR scl = 1'b1;
      #HALF;
    end
    sda_low = 1'b1;
    #HALF scl = 1'b0;
    #QTR;
  endtask : start
  // STOP: SDA rises while SCL is high.
  task automatic stop();
    sda_low = 1'b1;
    #QTR scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask : stop
  // Nine clocks; a 1 in d or k releases SDA, and the wire is sampled late in the high phase.
  task automatic xfer(input logic [7:0] d, input logic k, output logic [7:0] q, output logic a);
    logic [8:0] w;
    w = {d, k};
    for (int i = 8; i >= 0; i--) begin // Address and command go out MSB first.
      sda_low = !w[i];
      #QTR scl = 1'b1;
      #HALF w[i] = sda;
      scl = 1'b0;
      #QTR;
    end
    q = w[8:1];
    a = w[0];
  endtask : xfer
endmodule : iox_bus_master

`default_nettype wire

// >>> sim/tb_iox_expander.sv
// Bench for the four-bit I/O expander.
`timescale 1ns/1ps
`default_nettype none

module tb_iox_expander;
  logic mclk;
  logic rst_n;
  logic gl;
  logic [3:0] ext;
  logic scl;
  logic sda_low;
  logic sda_oe;
  logic [3:0] pin_o;
  logic [3:0] pin_oe;
  logic [3:0] pins;
  logic [7:0] q;
  logic a;
  int num_errors;
  int total_checks;
  localparam logic [31:0] DEF = 32'hff00fffa;
  // SDA has a pull-up; gl flips both bus lines for a short spike.
  wire logic sda = !(sda_low || sda_oe);
  assign pins = (pin_o & pin_oe) | (ext & ~pin_oe);
  iox_expander dut_u (.MCLK(mclk), .RST_N(rst_n), .SCL(scl ^ gl), .SDA(sda ^ gl), .SDA_DATA(),
    .SDA_OE(sda_oe), .GPIO_PIN(pins), .GPIO_PIN_LATCH(pin_o), .GPIO_PIN_OE(pin_oe));
  iox_bus_master m_u (.scl(scl), .sda_low(sda_low), .sda(sda));
  //////////////////////////////
  // 25 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Compare one value.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Write one data byte through a command byte.
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    m_u.start();
    m_u.xfer(8'h82, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    m_u.xfer(p, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    m_u.xfer(d, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    m_u.stop();
  endtask : wr
  // Set the pointer, then read n bytes; only the last is refused by the master.
  task automatic rd(input logic [7:0] p, input logic [7:0] e, input int n);
    m_u.start();
    m_u.xfer(8'h82, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    m_u.xfer(p, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    m_u.start();
    m_u.xfer(8'h83, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    for (int i = n; i > 0; i--) begin
      m_u.xfer(8'hff, i == 1, q, a);
      chk(q, e);
    end
    m_u.stop();
  endtask : rd
  // Counts and verdict.
  task automatic conclude();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  // Cut a hang short.
  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    conclude();
  end
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    gl = 1'b0;
    ext = 4'ha;
    num_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    chk({pin_oe, pin_o}, 8'h0f);
    for (int r = 0; r < 4; r++) begin
      rd(8'(r), DEF[r*8+:8], 1);
    end
    $display("Test defaults done");
    m_u.start();
    m_u.xfer(8'h84, 1'b1, q, a);
    chk({7'h0, a}, 8'h01);
    m_u.stop();
    $display("Test foreign address done");
    // A 40 ns spike on both lines in the high phase of the first address bit.
    fork
      wr(8'h01, 8'h05);
      begin
        #1080 gl = 1'b1;
        #40 gl = 1'b0;
      end
    join
    wr(8'h03, 8'h0c);
    chk({pin_oe, pin_o}, 8'h35);
    rd(8'h01, 8'hf5, 1);
    rd(8'h00, 8'hf9, 1);
    $display("Test outputs done");
    wr(8'h02, 8'h06);
    rd(8'h00, 8'hff, 3);
    rd(8'h02, 8'h06, 1);
    $display("Test polarity done");
    wr(8'h00, 8'h00);
    chk({pin_oe, pin_o}, 8'h35);
    rd(8'h01, 8'hf5, 1);
    rd(8'h03, 8'hfc, 1);
    $display("Test read-only done");
    conclude();
  end
endmodule : tb_iox_expander

`default_nettype wire
